// ===== rgbl_top.sv
// Boolean pin logic, delays, special inputs and cascade
`timescale 1ns/1ns
module rgbl_top #(
    parameter int NUM_OUT = rgbl_pkg::NUM_OUT,
    parameter int NUM_RAIL = rgbl_pkg::NUM_RAIL,
    parameter int TICK_CYCLES = rgbl_pkg::TICK_CYCLES,
    parameter logic [NUM_OUT-1:0] FAST_MASK = NUM_OUT'(rgbl_pkg::FAST_MASK_RST)
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [15:0] rdata_o,
    input wire logic [rgbl_pkg::NUM_IN-1:0] pin_in_i,
    output logic [NUM_OUT-1:0] pin_out_o,
    output logic [NUM_OUT-1:0] pin_oe_o,
    input wire logic [rgbl_pkg::NUM_TYPE-1:0][NUM_RAIL-1:0] rail_flags_i,
    input wire logic [NUM_RAIL-1:0] rail_en_req_i,
    input wire logic seq_done_i,
    input wire logic seq_down_i,
    output logic seq_timeout_fault_o,
    output logic [NUM_RAIL-1:0] margin_active_o,
    output logic margin_low_o,
    output logic [rgbl_pkg::STATE_SEL_W-1:0] rail_state_sel_o,
    output logic cascade_pg_o
);
    import rgbl_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES);

    logic [TW-1:0] tick_cnt_reg;
    logic tick_reg;
    logic [NUM_IN-1:0] in_pol_reg;
    rgbl_special_t spec_reg;
    logic [NUM_RAIL-1:0] pg_mask_reg;
    logic [NUM_RAIL-1:0] mrg_mask_reg;
    rgbl_pin_cfg_t cfg_reg [NUM_OUT];
    logic [15:0] dly_reg [NUM_OUT];
    rgbl_term_sel_t sel_reg [NUM_OUT][2];
    logic [5:0] type_reg [NUM_OUT][2];
    logic [NUM_RAIL-1:0] rmask_reg [NUM_OUT][2];
    logic [NUM_TYPE-1:0][NUM_RAIL-1:0] lat_reg;
    logic [NUM_OUT-1:0] out_lvl;
    logic [NUM_IN-1:0] in_act;
    logic [3:0] pin_a;
    logic [2:0] k_a;
    logic pin_hit, pin_ok, clr_wr, lat_clr, tmo_lvl, tmo_prev_reg, tmo_fall, seq_flag_reg, cfg_err_reg, cfg_reject;
    rgbl_pin_cfg_t cfg_wr;
    logic [4:0] rail_cnt;
    logic [15:0] rd_next;

    function automatic logic src_lvl(input rgbl_src_t s, input logic [NUM_IN-1:0] v);
        return s.en & v[s.idx];
    endfunction : src_lvl

    function automatic logic term_val(input rgbl_term_sel_t s, input logic [5:0] tc,
                                      input logic [NUM_RAIL-1:0] rm);
        logic [NUM_RAIL-1:0] f;
        logic ok;
        f = '0;
        ok = 1'b1;
        if (tc < 6'(NUM_TYPE)) begin
            f = rail_flags_i[tc];
        end else if (tc < 6'(2 * NUM_TYPE)) begin
            f = lat_reg[tc - 6'(NUM_TYPE)];
        end else begin
            ok = 1'b0;
        end
        return ok & (&(f | ~rm)) & (&(out_lvl[FEED_OUTS-1:0] | ~s.out_mask))
            & (&(in_act | ~s.in_mask));
    endfunction : term_val

    assign in_act = pin_in_i ^ in_pol_reg;
    assign pin_hit = addr_i[7];
    assign pin_a = addr_i[6:3];
    assign k_a = addr_i[2:0];
    assign pin_ok = pin_hit && ({1'b0, pin_a} < 5'(NUM_OUT));
    assign clr_wr = we_i && (addr_i == ADDR_CLEAR);

    // Millisecond time base
    always_ff @(posedge clk_i or posedge sys_rst_i) begin : tick_gen
        if (sys_rst_i) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    // Global setup registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin : glob_regs
        if (sys_rst_i) begin
            in_pol_reg <= '0;
            spec_reg <= '0;
            pg_mask_reg <= '0;
            mrg_mask_reg <= '0;
        end else if (we_i) begin
            case (addr_i)
                ADDR_IN_POL: in_pol_reg <= wdata_i[NUM_IN-1:0];
                ADDR_SPECIAL: spec_reg <= rgbl_special_t'(wdata_i);
                ADDR_PG_MASK: pg_mask_reg <= wdata_i[NUM_RAIL-1:0];
                ADDR_MRG_MASK: mrg_mask_reg <= wdata_i[NUM_RAIL-1:0];
            endcase
        end
    end

    always_comb begin
        rail_cnt = '0;
        for (int p = 0; p < NUM_OUT; p++) begin
            rail_cnt = rail_cnt + 5'(cfg_reg[p].rail_mode);
        end
    end

    always_comb begin
        cfg_wr = rgbl_pin_cfg_t'(wdata_i);
        cfg_reject = 1'b0;
        if (we_i && pin_ok && k_a == K_CFG && cfg_wr.rail_mode
            && !cfg_reg[pin_a].rail_mode && rail_cnt >= 5'(MAX_RAIL_EN)) begin
            cfg_wr.rail_mode = 1'b0;
            cfg_reject = 1'b1;
        end
    end

    // Per pin setup registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin : pin_regs
        if (sys_rst_i) begin
            for (int p = 0; p < NUM_OUT; p++) begin
                cfg_reg[p] <= '0;
                dly_reg[p] <= RST_WORD;
                for (int t = 0; t < 2; t++) begin
                    sel_reg[p][t] <= '0;
                    type_reg[p][t] <= '0;
                    rmask_reg[p][t] <= '0;
                end
            end
        end else if (we_i && pin_ok) begin
            for (int p = 0; p < NUM_OUT; p++) begin
                if (pin_a == 4'(p)) begin
                    case (k_a)
                        K_CFG: cfg_reg[p] <= cfg_wr;
                        K_DLY: dly_reg[p] <= wdata_i;
                        K_T0_SEL: sel_reg[p][0] <= rgbl_term_sel_t'(wdata_i);
                        K_T0_TYPE: type_reg[p][0] <= wdata_i[5:0];
                        K_T0_RAIL: rmask_reg[p][0] <= wdata_i[NUM_RAIL-1:0];
                        K_T1_SEL: sel_reg[p][1] <= rgbl_term_sel_t'(wdata_i);
                        K_T1_TYPE: type_reg[p][1] <= wdata_i[5:0];
                        K_T1_RAIL: rmask_reg[p][1] <= wdata_i[NUM_RAIL-1:0];
                    endcase
                end
            end
        end
    end

    assign lat_clr = (clr_wr && wdata_i[CLR_LATCH_BIT]) || src_lvl(spec_reg.clr, in_act);
    always_ff @(posedge clk_i or posedge sys_rst_i) begin : latch_store
        if (sys_rst_i) begin
            lat_reg <= '0;
        end else begin
            lat_reg <= (lat_reg & ~{(NUM_TYPE * NUM_RAIL){lat_clr}}) | rail_flags_i;
        end
    end

    assign tmo_lvl = src_lvl(spec_reg.tmo, in_act);
    assign tmo_fall = tmo_prev_reg && !tmo_lvl && spec_reg.tmo.en;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin : tmo_fault
        if (sys_rst_i) begin
            tmo_prev_reg <= 1'b0;
            seq_timeout_fault_o <= 1'b0;
            seq_flag_reg <= 1'b0;
            cfg_err_reg <= 1'b0;
        end else begin
            tmo_prev_reg <= tmo_lvl;
            seq_timeout_fault_o <= tmo_fall;
            seq_flag_reg <= tmo_fall || (seq_flag_reg && !(clr_wr && wdata_i[CLR_SEQ_BIT]));
            cfg_err_reg <= cfg_reject || (cfg_err_reg && !(clr_wr && wdata_i[CLR_CFG_BIT]));
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin : margin_ctl
        if (sys_rst_i) begin
            margin_active_o <= '0;
            margin_low_o <= 1'b0;
        end else begin
            margin_active_o <= src_lvl(spec_reg.mrg_en, in_act) ? mrg_mask_reg : '0;
            margin_low_o <= src_lvl(spec_reg.mrg_en, in_act) && src_lvl(spec_reg.mrg_dir, in_act);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin : cascade
        if (sys_rst_i) begin
            rail_state_sel_o <= '0;
            cascade_pg_o <= 1'b0;
        end else begin
            rail_state_sel_o <= in_act[STATE_SEL_W-1:0];
            cascade_pg_o <= seq_done_i && !seq_down_i
                && (&(rail_flags_i[ST_POWER_GOOD] | ~pg_mask_reg));
        end
    end

    for (genvar p = 0; p < NUM_OUT; p++) begin : g_pin
        logic t0, t1, res_reg, lvl_reg, pend_reg, dly_need, expire, drv, phys, used;
        logic [15:0] dcnt_reg;
        rgbl_dly_st_t st_reg;

        always_comb begin
            t0 = cfg_reg[p].t0_en && term_val(sel_reg[p][0], type_reg[p][0], rmask_reg[p][0]);
            t1 = cfg_reg[p].t1_en && term_val(sel_reg[p][1], type_reg[p][1], rmask_reg[p][1]);
        end
        assign out_lvl[p] = lvl_reg;

        always_ff @(posedge clk_i or posedge sys_rst_i) begin : logic_res
            if (sys_rst_i) begin
                res_reg <= 1'b0;
            end else if (cfg_reg[p].sm_mode) begin
                res_reg <= res_reg ? t0 : t1;
            end else begin
                res_reg <= t0 | t1;
            end
        end

        assign dly_need = (res_reg ? cfg_reg[p].dly_assert : cfg_reg[p].dly_deassert)
            && (dly_reg[p] != '0);
        assign expire = (dcnt_reg == dly_reg[p]);

        always_ff @(posedge clk_i or posedge sys_rst_i) begin : delay_fsm
            if (sys_rst_i) begin
                st_reg <= DLY_IDLE;
                lvl_reg <= 1'b0;
                pend_reg <= 1'b0;
                dcnt_reg <= '0;
            end else begin
                unique case (st_reg)
                    DLY_IDLE: begin
                        dcnt_reg <= '0;
                        if (res_reg != lvl_reg) begin
                            if (!dly_need) begin
                                lvl_reg <= res_reg;
                            end else begin
                                pend_reg <= res_reg;
                                st_reg <= cfg_reg[p].ignore ? DLY_LOCK : DLY_RUN;
                            end
                        end
                    end
                    DLY_RUN: begin
                        if (res_reg == lvl_reg) begin
                            st_reg <= DLY_IDLE;
                        end else if (expire) begin
                            lvl_reg <= res_reg;
                            st_reg <= DLY_IDLE;
                        end else if (tick_reg) begin
                            dcnt_reg <= dcnt_reg + 1'b1;
                        end
                    end
                    DLY_LOCK: begin
                        if (expire) begin
                            lvl_reg <= pend_reg;
                            st_reg <= DLY_IDLE;
                        end else if (tick_reg) begin
                            dcnt_reg <= dcnt_reg + 1'b1;
                        end
                    end
                    default: st_reg <= DLY_IDLE;
                endcase
            end
        end

        assign used = cfg_reg[p].t0_en || cfg_reg[p].t1_en || cfg_reg[p].rail_mode;
        assign drv = cfg_reg[p].rail_mode
            ? ((cfg_reg[p].rail_idx < 4'(NUM_RAIL)) && rail_en_req_i[cfg_reg[p].rail_idx])
            : lvl_reg;
        assign phys = drv ^ cfg_reg[p].act_low;

        always_ff @(posedge clk_i or posedge sys_rst_i) begin : pin_drive
            if (sys_rst_i) begin
                pin_out_o[p] <= 1'b0;
                pin_oe_o[p] <= FAST_MASK[p];
            end else if (!used) begin
                pin_out_o[p] <= 1'b0;
                pin_oe_o[p] <= FAST_MASK[p];
            end else if (cfg_reg[p].open_drain) begin
                pin_out_o[p] <= 1'b0;
                pin_oe_o[p] <= !phys;
            end else begin
                pin_out_o[p] <= phys;
                pin_oe_o[p] <= 1'b1;
            end
        end

        glitch_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
            st_reg == DLY_RUN && res_reg == lvl_reg |=> $stable(lvl_reg))
            else $error("Level changed after glitch");
        ignore_lock_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
            st_reg == DLY_LOCK && expire |=> lvl_reg == $past(pend_reg))
            else $error("Ignore mode lost pending value");
        sm_path_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
            cfg_reg[p].sm_mode && res_reg && t0 |=> res_reg)
            else $error("Path 0 true but result fell");
        od_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
            $past(used && cfg_reg[p].open_drain) && pin_oe_o[p] |-> !pin_out_o[p])
            else $error("Open drain pin drove high");
    end

    // Register read path
    always_comb begin
        rd_next = '0;
        if (pin_ok) begin
            case (k_a)
                K_CFG: rd_next = 16'(cfg_reg[pin_a]);
                K_DLY: rd_next = dly_reg[pin_a];
                K_T0_SEL: rd_next = 16'(sel_reg[pin_a][0]);
                K_T0_TYPE: rd_next = 16'(type_reg[pin_a][0]);
                K_T0_RAIL: rd_next = 16'(rmask_reg[pin_a][0]);
                K_T1_SEL: rd_next = 16'(sel_reg[pin_a][1]);
                K_T1_TYPE: rd_next = 16'(type_reg[pin_a][1]);
                K_T1_RAIL: rd_next = 16'(rmask_reg[pin_a][1]);
            endcase
        end else if (!pin_hit) begin
            case (addr_i)
                ADDR_IN_POL: rd_next = 16'(in_pol_reg);
                ADDR_SPECIAL: rd_next = 16'(spec_reg);
                ADDR_STATUS: rd_next = {14'h0000, cfg_err_reg, seq_flag_reg};
                ADDR_PG_MASK: rd_next = 16'(pg_mask_reg);
                ADDR_MRG_MASK: rd_next = 16'(mrg_mask_reg);
                ADDR_LEVEL: rd_next = 16'(out_lvl);
                default: rd_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin : read_port
        if (sys_rst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= re_i ? rd_next : '0;
        end
    end

    reset_pins_a: assert property (@(posedge clk_i)
        sys_rst_i |-> pin_oe_o == FAST_MASK && pin_out_o == '0)
        else $error("Pins wrong during reset");
    latch_keep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !lat_clr |=> (lat_reg & $past(lat_reg)) == $past(lat_reg))
        else $error("Latched flag dropped without clear");
    seq_fault_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        tmo_fall |=> seq_timeout_fault_o && seq_flag_reg ##1 !seq_timeout_fault_o || tmo_fall)
        else $error("Timeout source fall missed");
    margin_on_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        src_lvl(spec_reg.mrg_en, in_act) |=> margin_active_o == $past(mrg_mask_reg))
        else $error("Margin rails not set");
    margin_dir_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        margin_low_o |-> $past(src_lvl(spec_reg.mrg_dir, in_act)) && $past(spec_reg.mrg_en.en))
        else $error("Margin low without its sources");
    rail_cap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rail_cnt <= 5'(MAX_RAIL_EN))
        else $error("Too many rail enable pins");
    cascade_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        seq_down_i |=> !cascade_pg_o)
        else $error("Power good held while sequencing off");
    state_sel_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ##1 rail_state_sel_o == $past(in_act[STATE_SEL_W-1:0]))
        else $error("Selector does not follow inputs");

    glitch_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        g_pin[10].st_reg == DLY_RUN ##1 g_pin[10].st_reg == DLY_IDLE && $stable(out_lvl[10]));
    ignore_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        g_pin[10].st_reg == DLY_LOCK && g_pin[10].expire);
    fault_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) seq_timeout_fault_o);
    cascade_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) $fell(cascade_pg_o));
endmodule : rgbl_top

// ===== rgbl_pkg.sv
// Constants and types for the rail gpio boolean logic block
package rgbl_pkg;
    localparam int NUM_OUT = 16;
    localparam int NUM_IN = 8;
    localparam int NUM_RAIL = 12;
    localparam int NUM_TYPE = 17;
    localparam int FEED_OUTS = 8;
    localparam int MAX_RAIL_EN = 12;
    localparam int STATE_SEL_W = 3;
    localparam int CLK_MHZ = 10;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
    localparam logic [15:0] FAST_MASK_RST = 16'h00FF;
    localparam logic [7:0] ADDR_IN_POL = 8'h00;
    localparam logic [7:0] ADDR_SPECIAL = 8'h01;
    localparam logic [7:0] ADDR_CLEAR = 8'h02;
    localparam logic [7:0] ADDR_STATUS = 8'h03;
    localparam logic [7:0] ADDR_PG_MASK = 8'h04;
    localparam logic [7:0] ADDR_MRG_MASK = 8'h05;
    localparam logic [7:0] ADDR_LEVEL = 8'h06;
    localparam logic [2:0] K_CFG = 3'h0;
    localparam logic [2:0] K_DLY = 3'h1;
    localparam logic [2:0] K_T0_SEL = 3'h2;
    localparam logic [2:0] K_T0_TYPE = 3'h3;
    localparam logic [2:0] K_T0_RAIL = 3'h4;
    localparam logic [2:0] K_T1_SEL = 3'h5;
    localparam logic [2:0] K_T1_TYPE = 3'h6;
    localparam logic [2:0] K_T1_RAIL = 3'h7;
    localparam int CLR_LATCH_BIT = 0;
    localparam int CLR_SEQ_BIT = 1;
    localparam int CLR_CFG_BIT = 2;
    localparam logic [15:0] RST_WORD = 16'h0000;
    typedef enum logic [5:0] {
        ST_POWER_GOOD = 6'h00, ST_MARGIN_EN = 6'h01, ST_MARGIN_LOW = 6'h02,
        ST_OV_FAULT = 6'h03, ST_OV_WARN = 6'h04, ST_UV_WARN = 6'h05,
        ST_UV_FAULT = 6'h06, ST_TON_FAULT = 6'h07, ST_TOFF_WARN = 6'h08,
        ST_OC_FAULT = 6'h09, ST_OC_WARN = 6'h0A, ST_UC_FAULT = 6'h0B,
        ST_OT_FAULT = 6'h0C, ST_OT_WARN = 6'h0D, ST_UP_TIMEOUT = 6'h0E,
        ST_DOWN_TIMEOUT = 6'h0F, ST_WATCHDOG = 6'h10
    } rgbl_status_t;
    typedef enum logic [1:0] {
        DLY_IDLE = 2'b00,
        DLY_RUN = 2'b01,
        DLY_LOCK = 2'b11
    } rgbl_dly_st_t;
    typedef struct packed {
        logic [3:0] rail_idx;
        logic [2:0] rsvd;
        logic open_drain;
        logic act_low;
        logic rail_mode;
        logic dly_deassert;
        logic dly_assert;
        logic ignore;
        logic sm_mode;
        logic t1_en;
        logic t0_en;
    } rgbl_pin_cfg_t;
    typedef struct packed {
        logic [7:0] in_mask;
        logic [7:0] out_mask;
    } rgbl_term_sel_t;
    typedef struct packed {
        logic en;
        logic [2:0] idx;
    } rgbl_src_t;
    typedef struct packed {
        rgbl_src_t mrg_dir;
        rgbl_src_t mrg_en;
        rgbl_src_t clr;
        rgbl_src_t tmo;
    } rgbl_special_t;
endpackage : rgbl_pkg

// ===== rgbl_supply_model.sv
// Far-side model: rail supplies, fault source and cascade slave
`timescale 1ns/1ns
module rgbl_supply_model (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [11:0] pg_want_i,
    input wire logic [11:0] ovf_want_i,
    input wire logic cascade_pg_i,
    output logic [16:0][11:0] rail_flags_o,
    output logic slave_started_o
);
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rail_flags_o <= '0;
        end else begin
            rail_flags_o <= '0;
            rail_flags_o[0] <= pg_want_i;
            rail_flags_o[3] <= ovf_want_i;
        end
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            slave_started_o <= 1'b0;
        end else begin
            slave_started_o <= cascade_pg_i;
        end
    end
endmodule : rgbl_supply_model

// ===== rail_gpio_boolean_logic_bench.sv
// Self-checking bench for the rail gpio boolean logic block
`timescale 1ns/1ns
module rail_gpio_boolean_logic_bench;
    import rgbl_pkg::*;
    logic clk_i = 1'b0, sys_rst_i = 1'b0, we_i = 1'b0, re_i = 1'b0, seq_done = 1'b0, seq_down = 1'b0;
    logic [7:0] addr_i = 8'h00, pin_in = 8'h00, pol;
    logic [15:0] wdata_i = 16'h0000, rdata_o, pin_out, pin_oe, rd_val;
    logic [11:0] pg_want = 12'h000, ovf_want = 12'h000, en_req = 12'h000, mrg_act;
    logic [16:0][11:0] flags;
    logic [2:0] sel;
    logic tmo, mrg_low, cpg, slave_on;
    logic [15:0] mg_exp [4] = '{16'h80A5, 16'h00A5, 16'h0000, 16'h0000};
    // Seed 55192
    logic [31:0] seed = 32'h0000D798, r;
    int n_fail = 0, compares = 0, cnt;
    always #50 clk_i = ~clk_i;
    rgbl_top #(.TICK_CYCLES(4)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .pin_in_i(pin_in),
        .pin_out_o(pin_out), .pin_oe_o(pin_oe), .rail_flags_i(flags), .rail_en_req_i(en_req),
        .seq_done_i(seq_done), .seq_down_i(seq_down), .seq_timeout_fault_o(tmo),
        .margin_active_o(mrg_act), .margin_low_o(mrg_low), .rail_state_sel_o(sel), .cascade_pg_o(cpg));
    rgbl_supply_model i_far (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pg_want_i(pg_want),
        .ovf_want_i(ovf_want), .cascade_pg_i(cpg), .rail_flags_o(flags), .slave_started_o(slave_on));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [2:0] exp_sel(input logic [7:0] p, input logic [7:0] q);
        return 3'(p ^ q);
    endfunction : exp_sel
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wt
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 rd_val = rdata_o;
    endtask : rd
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    initial begin
        sys_rst_i <= 1'b1;
        wt(1);
        chk(pin_oe, 16'h00FF);
        chk(pin_out, 16'h0000);
        @(posedge clk_i) sys_rst_i <= 1'b0;
        wr(8'hC0, 16'h0001);
        wr(8'hC2, 16'h0100);
        wr(8'hC4, 16'h0001);
        repeat (20) begin
            r = xs();
            pol = r[15:8];
            wr(ADDR_IN_POL, {8'h00, pol});
            @(posedge clk_i);
            pin_in <= r[7:0];
            pg_want <= r[27:16];
            wt(6);
            chk(sel, exp_sel(pin_in, pol));
            chk(pin_out[8], (pin_in[0] ^ pol[0]) & pg_want[0]);
            rd(ADDR_IN_POL);
            chk(rd_val, {8'h00, pol});
        end
        rd(8'h07);
        chk(rd_val, 16'h0000);
        wr(ADDR_IN_POL, 16'h0000);
        @(posedge clk_i) pin_in <= 8'h00;
        $display("test random logic done");
        wr(8'hC8, 16'h0001);
        wr(8'hCB, 16'h0014);
        wr(8'hCC, 16'h0001);
        @(posedge clk_i) ovf_want <= 12'h001;
        @(posedge clk_i) ovf_want <= 12'h000;
        wt(8);
        chk(pin_out[9], 1'b1);
        wr(ADDR_CLEAR, 16'h0001);
        wt(6);
        chk(pin_out[9], 1'b0);
        @(posedge clk_i) ovf_want <= 12'h001;
        @(posedge clk_i) ovf_want <= 12'h000;
        wt(8);
        rd(ADDR_LEVEL);
        chk(rd_val[9], 1'b1);
        wr(ADDR_SPECIAL, 16'h00F0);
        @(posedge clk_i) pin_in[7] <= 1'b1;
        wt(6);
        chk(pin_out[9], 1'b0);
        @(posedge clk_i) pin_in[7] <= 1'b0;
        $display("test latched flag done");
        wr(8'hD1, 16'h0003);
        wr(8'hD2, 16'h0200);
        for (int i = 0; i < 2; i++) begin
            wr(8'hD0, i ? 16'h0039 : 16'h0031);
            wt(20);
            @(posedge clk_i) pin_in[1] <= 1'b1;
            repeat (2) @(posedge clk_i);
            pin_in[1] <= 1'b0;
            cnt = 0;
            repeat (40) begin
                wt(1);
                cnt += int'(pin_out[10]);
            end
            chk(16'(cnt >= 8), 16'(i));
        end
        $display("test delay done");
        wr(8'hD8, 16'h0007);
        wr(8'hDA, 16'h0400);
        wr(8'hDD, 16'h0800);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i) pin_in[3:2] <= 2'(8'h1D >> (2 * i));
            wt(6);
            chk(pin_out[11], 4'h6 >> i & 4'h1);
        end
        $display("test state machine done");
        wr(ADDR_SPECIAL, 16'hED0C);
        wr(ADDR_MRG_MASK, 16'h00A5);
        @(posedge clk_i) pin_in[4] <= 1'b1;
        wt(3);
        @(posedge clk_i) pin_in[4] <= 1'b0;
        cnt = 0;
        repeat (6) begin
            wt(1);
            cnt += int'(tmo);
        end
        chk(16'(cnt), 16'h0001);
        rd(ADDR_STATUS);
        chk(rd_val[0], 1'b1);
        wr(ADDR_CLEAR, 16'h0002);
        rd(ADDR_STATUS);
        chk(rd_val[0], 1'b0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i) pin_in[6:5] <= 2'(8'h87 >> (2 * i));
            wt(4);
            chk({mrg_low, 3'h0, mrg_act}, mg_exp[i]);
        end
        $display("test special inputs done");
        wr(ADDR_PG_MASK, 16'h0003);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            pg_want <= (i == 1) ? 12'h002 : 12'h003;
            seq_done <= 1'b1;
            seq_down <= (i == 2);
            wt(4);
            chk({cpg, slave_on}, (i == 0) ? 2'h3 : 2'h0);
        end
        wr(8'hE0, 16'h21C0);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i) en_req <= i ? 12'h004 : 12'h000;
            wt(4);
            chk({pin_oe[12], pin_out[12]}, i ? 2'h2 : 2'h0);
        end
        for (int p = 0; p < 14; p++) begin
            if (p != 12) wr(8'(8'h80 + 8 * p), 16'h0040);
        end
        rd(8'hE8);
        chk(rd_val[6], 1'b0);
        rd(ADDR_STATUS);
        chk(rd_val[1], 1'b1);
        $display("test cascade and enables done");
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        test_done();
    end
endmodule : rail_gpio_boolean_logic_bench
